// File: hdl/ocs_ctrl.sv
// ocs_ctrl: oscillator source selection, clock derivation and switch control.
// assumes apb master on pclk; source clocks arrive asynchronous and are sampled here.
`timescale 1ns/1ps
module ocs_ctrl
	import ocs_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic                   pready,
	output logic [31:0]            prdata,
	output logic                   pslverr,
	input  wire ocs_pkg::ocs_mode_t mode_in,
	input  wire logic              internal_osc_clock,
	input  wire logic              crystal_clock,
	input  wire logic              resistor_cap_clock,
	input  wire logic              crystal_input_pin,
	output ocs_pkg::ocs_pin_t      pin_ff,
	output logic                   quad_bus_clock,
	output logic                   double_bus_clock,
	output logic                   internal_osc_enable,
	output logic                   external_osc_enable,
	output logic [7:0]             trim_factor
);
	import ocs_pkg::*;

	logic [7:0]  trim_ff;
	logic [1:0]  sel_ff;
	logic        outen_ff;
	logic        req_ff;
	logic        eng_ff;
	logic        int_stop_ff;
	ocs_state_t  st_ff;
	ocs_state_t  nxt_st;
	logic [1:0]  edge_cnt_ff;
	logic [6:0]  mode_s1_ff;
	logic [6:0]  mode_s2_ff;
	logic [3:0]  clk_s1_ff;
	logic [3:0]  clk_s2_ff;
	logic [3:0]  clk_s3_ff;
	logic        ext_src;
	logic        ext_prev;
	logic        ext_rise;
	logic        src_clk;
	logic        quad_ff;
	logic        dbl_ff;
	logic        quad_prev_ff;
	logic        run;
	logic        req_block;
	logic        both_low;
	logic        wr;
	logic        rd;
	ocs_mode_t   mode_s;

	// address decode used by both read and write paths
	function automatic logic [1:0] ocs_dec(input logic [7:0] a);
		case (a)
			OCS_ADDR_STATUS: ocs_dec = 2'h1;
			OCS_ADDR_TRIM:   ocs_dec = 2'h2;
			OCS_ADDR_CFG:    ocs_dec = 2'h3;
			default:         ocs_dec = 2'h0;
		endcase
	endfunction

	assign wr     = psel & penable & pwrite;
	assign rd     = psel & penable & ~pwrite;
	assign mode_s = ocs_mode_t'(mode_s2_ff);

	// two-flop synchronisers for the mode levels from the system unit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			mode_s1_ff <= 7'h00;
			mode_s2_ff <= 7'h00;
		end
		else
		begin
			mode_s1_ff <= mode_in;
			mode_s2_ff <= mode_s1_ff;
		end
	end

	// source clocks: two flops, then a third kept only for edge detection
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			clk_s1_ff <= 4'h0;
			clk_s2_ff <= 4'h0;
			clk_s3_ff <= 4'h0;
		end
		else
		begin
			clk_s1_ff <= {crystal_input_pin, resistor_cap_clock, crystal_clock,
				internal_osc_clock};
			clk_s2_ff <= clk_s1_ff;
			clk_s3_ff <= clk_s2_ff;
		end
	end

	// pick the selected external source; sampled clocks limit rates to under pclk/2
	always_comb
	begin
		ext_src  = 1'b0;
		ext_prev = 1'b0;
		case (sel_ff)
			OCS_SRC_EXT:
			begin
				ext_src  = clk_s2_ff[3];
				ext_prev = clk_s3_ff[3];
			end
			OCS_SRC_RC:
			begin
				ext_src  = clk_s2_ff[2];
				ext_prev = clk_s3_ff[2];
			end
			OCS_SRC_XTL:
			begin
				ext_src  = clk_s2_ff[1];
				ext_prev = clk_s3_ff[1];
			end
			default:
			begin
				ext_src  = 1'b0;
				ext_prev = 1'b0;
			end
		endcase
	end

	assign ext_rise = ext_src & ~ext_prev;
	// quad clock is the engaged source itself, internal until the switch
	assign src_clk  = eng_ff ? ext_src : clk_s2_ff[0];
	// stop and oscillator enable gate the source; wait and break do not
	assign run      = mode_s.osc_enable_from_sysint & ~mode_s.stop_mode;
	assign req_block = mode_s.monitor_bypass | mode_s.first_test_mode |
		mode_s.second_test_mode;
	// both sampled clocks low: the only moment the quad source may be swapped
	assign both_low  = ~ext_src & ~clk_s2_ff[0];

	// bus clock ports come straight from their flops
	assign quad_bus_clock   = quad_ff;
	assign double_bus_clock = dbl_ff;

	// apb register writes
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			trim_ff  <= OCS_TRIM_RST;
			sel_ff   <= OCS_SEL_RST;
			outen_ff <= 1'b0;
			req_ff   <= 1'b0;
		end
		else if (wr)
		begin
			case (ocs_dec(paddr))
				2'h1: req_ff <= pwdata[OCS_STAT_REQ_BIT];
				2'h2: trim_ff <= pwdata[7:0];
				2'h3:
				begin
					sel_ff   <= pwdata[OCS_CFG_SEL_LSB +: 2];
					outen_ff <= pwdata[OCS_CFG_OUTEN_BIT];
				end
				default: req_ff <= req_ff;
			endcase
		end
	end

	// apb answer: zero wait states, error on unmapped address
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready  <= 1'b0;
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & (ocs_dec(paddr) == 2'h0);
			prdata  <= 32'h0000_0000;
			if (psel & ~penable & ~pwrite)
			begin
				case (ocs_dec(paddr))
					2'h1: prdata <= {30'h0, req_ff, eng_ff};
					2'h2: prdata <= {24'h0, trim_ff};
					2'h3: prdata <= {29'h0, outen_ff, sel_ff};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// switch sequencer next state
	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			OCS_ST_INT:
				if (req_ff & ~req_block & (sel_ff != OCS_SRC_INT))
					nxt_st = OCS_ST_WAIT;
			OCS_ST_WAIT:
				if (ext_rise & (edge_cnt_ff == OCS_EXT_EDGES - 2'h1))
					nxt_st = OCS_ST_ENGAGE;
			OCS_ST_ENGAGE:
				if (both_low)
					nxt_st = OCS_ST_EXT;
			OCS_ST_EXT:
				nxt_st = OCS_ST_EXT;
			default:
				nxt_st = OCS_ST_INT;
		endcase
	end

	// sequencer state register
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			st_ff <= OCS_ST_INT;
		else
			st_ff <= nxt_st;
	end

	// external rising edges seen while waiting; cleared in any other state
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			edge_cnt_ff <= 2'h0;
		else if (st_ff != OCS_ST_WAIT)
			edge_cnt_ff <= 2'h0;
		else if (ext_rise)
			edge_cnt_ff <= edge_cnt_ff + 2'h1;
	end

	// engaged flag set only while both clocks are low, so the swap cannot glitch
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			eng_ff <= 1'b0;
		else if ((st_ff == OCS_ST_ENGAGE) & both_low)
			eng_ff <= 1'b1;
	end

	// internal oscillator stop, one cycle after the engaged flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_stop_ff <= 1'b0;
		else if (st_ff == OCS_ST_EXT)
			int_stop_ff <= 1'b1;
	end

	// quad clock: running source resampled; stop or enable low holds it at 0
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			quad_ff      <= 1'b0;
			quad_prev_ff <= 1'b0;
		end
		else
		begin
			quad_ff      <= run & src_clk;
			quad_prev_ff <= quad_ff;
		end
	end

	// double clock toggles on each quad rise; the system unit halves it again
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			dbl_ff <= 1'b0;
		else if (quad_ff & ~quad_prev_ff)
			dbl_ff <= ~dbl_ff;
	end

	// crystal output pin function, from select and enable bit, not engagement
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_ff <= '0;
		else
		begin
			pin_ff.amp_enable         <= (sel_ff == OCS_SRC_XTL);
			pin_ff.clk_out            <= ((sel_ff == OCS_SRC_INT) | (sel_ff == OCS_SRC_RC))
				& outen_ff & quad_ff;
			pin_ff.port_a_bit_four_io <= (sel_ff == OCS_SRC_EXT) |
				(((sel_ff == OCS_SRC_INT) | (sel_ff == OCS_SRC_RC)) & ~outen_ff);
		end
	end

	// internal oscillator enable; once stopped only reset brings it back
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			internal_osc_enable <= 1'b0;
		else
			internal_osc_enable <= run & ~int_stop_ff;
	end

	// external generator enable: a live request or an engaged source
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			external_osc_enable <= 1'b0;
		else
			external_osc_enable <= run & (sel_ff != OCS_SRC_INT) &
				((req_ff & ~req_block) | eng_ff);
	end

	// trim factor handed to the analog oscillator
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			trim_factor <= OCS_TRIM_RST;
		else
			trim_factor <= trim_ff;
	end

endmodule

// File: hdl/ocs_pkg.sv
// ocs_pkg: register map, field layout, reset values and timing for the oscillator control.
// assumes a 32-bit apb slave on pclk at 125 mhz.
package ocs_pkg;
	// register byte addresses
	localparam logic [7:0] OCS_ADDR_STATUS = 8'h00;
	localparam logic [7:0] OCS_ADDR_TRIM   = 8'h04;
	localparam logic [7:0] OCS_ADDR_CFG    = 8'h08;
	// status register fields
	localparam int OCS_STAT_REQ_BIT = 1;
	localparam int OCS_STAT_ENG_BIT = 0;
	// config register fields
	localparam int OCS_CFG_SEL_LSB  = 0;
	localparam int OCS_CFG_OUTEN_BIT = 2;
	// reset values
	localparam logic [7:0] OCS_TRIM_RST = 8'h80;
	localparam logic [1:0] OCS_SEL_RST  = 2'h0;
	// nominal internal oscillator, khz
	localparam int OCS_INT_FREQ_KHZ = 12800;
	// external rising edges needed before the switch
	localparam logic [1:0] OCS_EXT_EDGES = 2'h2;
	// source select codes
	typedef enum logic [1:0] {
		OCS_SRC_INT = 2'h0,
		OCS_SRC_EXT = 2'h1,
		OCS_SRC_RC  = 2'h2,
		OCS_SRC_XTL = 2'h3
	} ocs_src_t;
	// switch sequencer, gray along the path
	typedef enum logic [1:0] {
		OCS_ST_INT    = 2'h0,
		OCS_ST_WAIT   = 2'h1,
		OCS_ST_ENGAGE = 2'h3,
		OCS_ST_EXT    = 2'h2
	} ocs_state_t;
	// mode inputs from the system integration unit
	typedef struct packed {
		logic osc_enable_from_sysint;
		logic stop_mode;
		logic wait_mode;
		logic break_mode;
		logic monitor_bypass;
		logic first_test_mode;
		logic second_test_mode;
	} ocs_mode_t;
	// crystal output pin control
	typedef struct packed {
		logic amp_enable;
		logic clk_out;
		logic port_a_bit_four_io;
	} ocs_pin_t;
endpackage

// File: verification/ocs_src_model.sv
// ocs_src_model: behavioural far-side oscillators and external clock.
// assumes enables from ocs_ctrl; every source stays well under 31 mhz.
`timescale 1ns/1ps
module ocs_src_model
(
	input  wire logic int_en,
	input  wire logic ext_en,
	input  wire logic ext_dead,
	output logic      int_clk,
	output logic      xtal_clk,
	output logic      rc_clk,
	output logic      ext_clk
);
	// sources stand still low while disabled, never freeze high
	initial {int_clk, xtal_clk, rc_clk, ext_clk} = 4'h0;
	always #40 int_clk = int_en ? ~int_clk : 1'b0;
	always #50 xtal_clk = (ext_en && !ext_dead) ? ~xtal_clk : 1'b0;
	always #60 rc_clk = (ext_en && !ext_dead) ? ~rc_clk : 1'b0;
	// external clock source is free running until it dies
	always #70 ext_clk = ext_dead ? 1'b0 : ~ext_clk;
endmodule

// File: verification/ocs_ctrl_asserts.sv
// ocs_ctrl_asserts: port-level checks of the oscillator control.
// assumes binding into ocs_ctrl, single pclk domain.
`timescale 1ns/1ps
module ocs_ctrl_asserts
	import ocs_pkg::*;
(
	input wire logic               pclk,
	input wire logic               presetn,
	input wire logic               psel,
	input wire logic               penable,
	input wire logic               pwrite,
	input wire logic [7:0]         paddr,
	input wire logic [31:0]        pwdata,
	input wire logic               pready,
	input wire logic               pslverr,
	input wire ocs_pkg::ocs_mode_t mode_in,
	input wire ocs_pkg::ocs_pin_t  pin_ff,
	input wire logic               internal_osc_enable,
	input wire logic               external_osc_enable,
	input wire logic [7:0]         trim_factor
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// zero wait states, so setup earns ready at once
	chk_ready_next: assert property (psel && !penable |=> pready)
		else $error("ready missing after setup");
	chk_unmapped_err: assert property (psel && penable && pready && paddr > OCS_ADDR_CFG |-> pslverr)
		else $error("no error on unmapped address");
	chk_trim_write: assert property (psel && penable && pwrite && paddr == OCS_ADDR_TRIM
		|-> ##2 trim_factor == $past(pwdata[7:0], 2)) else $error("trim write lost");
	chk_trim_reset: assert property ($rose(presetn) |-> trim_factor == OCS_TRIM_RST)
		else $error("trim reset value wrong");
	// pin has at most one owner at a time
	chk_pin_owner: assert property ($onehot0(pin_ff)) else $error("pin owners clash");
	// margin covers the two sync flops and the enable register
	chk_stop_gate: assert property (mode_in.stop_mode [*6] |-> !internal_osc_enable && !external_osc_enable)
		else $error("stop left a source on");
	chk_osc_off: assert property (!mode_in.osc_enable_from_sysint [*6] |-> !internal_osc_enable)
		else $error("oscillator enable ignored");
	chk_no_fallback: assert property (external_osc_enable && !internal_osc_enable |=> !internal_osc_enable)
		else $error("internal oscillator came back");
endmodule

bind ocs_ctrl ocs_ctrl_asserts u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.pslverr(pslverr), .mode_in(mode_in), .pin_ff(pin_ff), .trim_factor(trim_factor),
	.internal_osc_enable(internal_osc_enable), .external_osc_enable(external_osc_enable));

// File: verification/tb_oscillator_clock_source_control.sv
// tb_oscillator_clock_source_control: self-checking bench for ocs_ctrl.
// assumes ocs_src_model on the far side and the bound checker.
`timescale 1ns/1ps
module tb_oscillator_clock_source_control;
	import ocs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ie, ee, dead;
	logic        ic, xc, rcc, ec, qbc, dbc;
	int          drises;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	ocs_mode_t   mode;
	ocs_pin_t    pin;
	int          n_errors, samples_checked, rises;
	ocs_ctrl dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
		.pslverr(pslverr), .mode_in(mode), .internal_osc_clock(ic), .crystal_clock(xc),
		.resistor_cap_clock(rcc), .crystal_input_pin(ec), .pin_ff(pin), .quad_bus_clock(qbc),
		.double_bus_clock(dbc), .internal_osc_enable(ie), .external_osc_enable(ee),
		.trim_factor());
	ocs_src_model src_u (.int_en(ie), .ext_en(ee), .ext_dead(dead), .int_clk(ic),
		.xtal_clk(xc), .rc_clk(rcc), .ext_clk(ec));
	initial
	begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// clock-out activity seen on the shared pin
	always @(posedge pin.clk_out) rises++;
	always @(posedge dbc) drises++;
	task automatic complete_run;
	begin
		$display("checks=%0d errors=%0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	end
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
	begin
		samples_checked++;
		if (seen !== exp)
		begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// request held until ready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
	begin
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end
		while (pready !== 1'b1 && i < 20);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 20)
		begin
			n_errors++;
			complete_run();
		end
	end
	endtask
	task automatic rst;
	begin
		presetn <= 1'b0;
		cyc(2);
		presetn <= 1'b1;
	end
	endtask
	task automatic t_regs;
	begin
		rst();
		apb(0, OCS_ADDR_TRIM, 0);
		check(rd, 32'h80);
		apb(0, OCS_ADDR_STATUS, 0);
		check(rd, 32'h0);
		check(ie, 1'b1);
		apb(1, OCS_ADDR_TRIM, 32'h7F);
		apb(0, OCS_ADDR_TRIM, 0);
		check(rd, 32'h7F);
		apb(0, 8'h0C, 0);
		check(err, 1'b1);
		$display("regs test done");
	end
	endtask
	// every select and enable pair, wait and break held on
	task automatic t_pins;
		logic [1:0] s;
	begin
		mode <= 7'h58;
		for (int k = 0; k < 8; k++)
		begin
			s = k[1:0];
			apb(1, OCS_ADDR_CFG, k);
			cyc(8);
			rises = 0;
			drises = 0;
			cyc(40);
			check({pin.amp_enable, pin.port_a_bit_four_io},
				{s == 3, s == 1 || ((s == 0 || s == 2) && !k[2])});
			check(rises > 0, k[2] && (s == 0 || s == 2));
			check(drises > 0, 1'b1);
		end
		apb(1, OCS_ADDR_CFG, 4);
		mode <= 7'h60;
		cyc(8);
		rises = 0;
		drises = 0;
		cyc(40);
		check(rises, 0);
		check({drises > 0, qbc}, 2'h0);
		mode <= 7'h00;
		cyc(8);
		check({ie, ee}, 2'h0);
		mode <= 7'h40;
		$display("pin test done");
	end
	endtask
	task automatic t_switch;
		int i;
	begin
		rst();
		apb(1, OCS_ADDR_STATUS, 2);
		cyc(40);
		apb(0, OCS_ADDR_STATUS, 0);
		check(rd, 32'h2);
		rst();
		mode <= 7'h42;
		apb(1, OCS_ADDR_CFG, 2);
		apb(1, OCS_ADDR_STATUS, 2);
		cyc(40);
		apb(0, OCS_ADDR_STATUS, 0);
		check(rd, 32'h2);
		mode <= 7'h40;
		i = 0;
		do
		begin
			apb(0, OCS_ADDR_STATUS, 0);
			i++;
		end
		while (rd[0] !== 1'b1 && i < 60);
		check(rd, 32'h3);
		cyc(4);
		check(ie, 1'b0);
		dead <= 1'b1;
		cyc(60);
		apb(0, OCS_ADDR_STATUS, 0);
		check({rd[1:0], ie}, 3'h6);
		$display("switch test done");
	end
	endtask
	initial
	begin
		{presetn, psel, penable, pwrite, dead} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		mode = 7'h40;
		n_errors = 0;
		samples_checked = 0;
		rises = 0;
		t_regs();
		t_pins();
		t_switch();
		complete_run();
	end
endmodule
